// ==== flash_prog_defines.svh ====
// Timing constants for the flash programming-mode timing sequencer.
// What the document requires
// R1 - Pulse counting on the mode-select pin starts no earlier than 7.42 ms.
// R2 - Pulse counting ends by 33.8 ms after reset; pulses must fall inside.
// R3 - Programmer should centre its pulse train in the counting window.
// R4 - Clocked-serial: programmer waits 55.56 ms before the reset command.
// R5 - UART: programmer waits 55.62 ms, plus 2^16 periods on crystal clock.
// R6 - UART: at least 3.75 ms between the two low-level pulses.
// R7 - UART: at least 3.75 ms after the second pulse before commands.
// R8 - Each UART low pulse lasts one 00H byte at 9600 bps.
// R9 - Every programmer response timeout is at least 3 s.
// R10 - Data frames sent 29.63 us apart serial, 26.25 us apart UART.
// R11 - Programmer sends the next frame only after the minimum wait.
// R12 - Programmer receives the next frame only after the minimum wait.
// R13 - Device is ready once the minimum wait after a transfer elapses.
// R14 - Serial: 13502.75 us per block after status before data frames.
// R15 - Serial: status command after minimum wait; no retry without ACK.
// R16 - Commands finish between minimum and maximum; late finish is timeout.
// R17 - Chip erase lies within base plus per-block bounds over all blocks.
// R18 - Block erase bounds are base plus per-pass plus per-block terms.
// R19 - Each 256-byte program unit takes 12781.25 to 140019.13 us.
// R20 - Block 0 program takes 103518 to 776321.25 us; others 24393.63 max.
// R21 - Erase passes use largest power-of-two group dividing start, fitting.
// R22 - UART: programmer enables its receiver before sending the command.
// R23 - Programmer sequences supply, mode-select pin and reset release.
// R24 - Mode-select pulse phases last between 10 us and 100 us.
`ifndef FLASH_PROG_DEFINES_SVH
`define FLASH_PROG_DEFINES_SVH

`define CLK_PERIOD_NS 8
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_MAX(ns) ((ns) / `CLK_PERIOD_NS)
`define DIV_UP(ns, p) (((ns) + (p) - 1) / (p))
`define DIV_DN(ns, p) ((ns) / (p))

`define MODE_CNT_START_NS  7420000
`define MODE_CNT_FINISH_NS 33800000

`define WAIT_DR_CSI_NS      29630
`define WAIT_DR_UART_NS     26250
`define WAIT_DT_CSI_NS      23130
`define WAIT_SF_CSI_NS      75630
`define WAIT_FD1_CSI_NS     13502750
`define WAIT_FD2_SIG_CSI_NS 86630
`define WAIT_FD2_VER_CSI_NS 61000
`define WAIT_FD3_CSI_NS     3075
`define WAIT_FD3_UART_NS    29630
`define WAIT_COM_CSI_NS     36000
`define WAIT_COM_UART_NS    34880

`define CE_BASE_MIN_NS   92770880
`define CE_BASE_MAX_NS   945798500
`define ERASE_BLK_MIN_NS 11788875
`define CE_BLK_MAX_NS    165043250
`define BE_BASE_NS       316750
`define BE_PASS_MIN_NS   13522000
`define BE_PASS_MAX_NS   190196000
`define BE_BLK_MAX_NS    164444500
`define PU_MIN_NS        12781250
`define PU_MAX_NS        140019130
`define PB0_MIN_NS       103518000
`define PB0_MAX_NS       776321250
`define PBN_MAX_NS       24393630

`define MAX_GROUP_LOG2 7
`define MAX_GROUP      128

`endif

// ==== flash_prog_pkg.sv ====
// Types shared by the flash programming-mode timing sequencer.
package flash_prog_pkg;
  typedef enum logic [1:0] {
    CMD_IDLE = 2'h0,
    CMD_PLAN = 2'h1,
    CMD_RUN  = 2'h3,
    CMD_END  = 2'h2
  } cmd_state_t;

  typedef enum logic [1:0] {
    CHIP_ERASE  = 2'h0,
    BLOCK_ERASE = 2'h1,
    PROG_UNIT   = 2'h2,
    PROG_BLOCK  = 2'h3
  } cmd_kind_t;

  typedef enum logic [2:0] {
    XFER_DATA_RX   = 3'h0,
    XFER_DATA_TX   = 3'h1,
    XFER_STATUS_RQ = 3'h2,
    XFER_FD1       = 3'h3,
    XFER_FD2_SIG   = 3'h4,
    XFER_FD2_VER   = 3'h5,
    XFER_FD3       = 3'h6,
    XFER_COM       = 3'h7
  } xfer_kind_t;
endpackage

// ==== min_wait_timer.sv ====
// Down counter that holds off readiness for a loaded number of cycles.
`timescale 1ns/1ps
`default_nettype none
module min_wait_timer (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Load request.
  input  wire logic        load,
  input  wire logic [31:0] load_value,
  // State.
  output logic             ready
);
  logic [31:0] count;
  logic [31:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_value;
    end else if (count != 32'h0) begin
      next_count = count - 32'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 32'h0;
    end else begin
      count <= next_count;
    end
  end

  assign ready = (count == 32'h0);
endmodule
`default_nettype wire

// ==== erase_pass_planner.sv ====
// Picks the size of the next simultaneous erase group.
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_defines.svh"
module erase_pass_planner (
  // Pass request.
  input  wire logic [7:0] start_block,
  input  wire logic [7:0] remaining,
  // Chosen group.
  output logic      [2:0] size_log2,
  output logic      [7:0] size
);
  // Scanning upward keeps the last fitting power of two, the largest one.
  always_comb begin
    size_log2 = 3'h0;
    for (int k = 1; k <= `MAX_GROUP_LOG2; k++) begin
      if (((8'h1 << k) <= remaining) &&
          ((start_block & ((8'h1 << k) - 8'h1)) == 8'h0)) begin // R21
        size_log2 = 3'(k);
      end
    end
    size = 8'h1 << size_log2;
  end
endmodule
`default_nettype wire

// ==== flash_prog_mode_timing.sv ====
// Mode entry counter, link wait gating and command completion windows.
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_defines.svh"
module flash_prog_mode_timing #(
  // Divides the millisecond-scale counts to shorten runs; 1 is real time.
  parameter logic [31:0] TIME_DIV = 32'h1
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Mode entry.
  input  wire logic       flash_mode_select_pin,
  output logic            count_window_open,
  output logic [7:0]      mode_count,
  output logic            mode_count_valid,
  // Link transfer gating.
  input  wire logic       link_uart,
  input  wire logic       xfer_end,
  input  wire logic [2:0] xfer_kind,
  input  wire logic [7:0] xfer_blocks,
  output logic            link_ready,
  // Command request.
  input  wire logic       cmd_start,
  input  wire logic [1:0] cmd_kind,
  input  wire logic [7:0] cmd_first_block,
  input  wire logic [7:0] cmd_block_count,
  input  wire logic       array_done,
  output logic            cmd_busy,
  output logic            cmd_done,
  output logic            cmd_timeout,
  // Erase pass descriptors.
  output logic            erase_pass_valid,
  output logic [7:0]      erase_pass_block,
  output logic [7:0]      erase_pass_size,
  output logic [7:0]      erase_pass_count
);
  localparam logic [31:0] DR_CSI_CYC  = 32'(`CYC_MIN(`WAIT_DR_CSI_NS));
  localparam logic [31:0] DR_UART_CYC = 32'(`CYC_MIN(`WAIT_DR_UART_NS));
  localparam logic [31:0] DT_CSI_CYC  = 32'(`CYC_MIN(`WAIT_DT_CSI_NS));
  localparam logic [31:0] FD3_CSI_CYC = 32'(`CYC_MIN(`WAIT_FD3_CSI_NS));
  localparam logic [31:0] FD3_UART_CYC = 32'(`CYC_MIN(`WAIT_FD3_UART_NS));
  localparam logic [31:0] SF_CSI_CYC = 32'(`CYC_MIN(`WAIT_SF_CSI_NS));
  localparam logic [31:0] FD2_SIG_CYC = 32'(`CYC_MIN(`WAIT_FD2_SIG_CSI_NS));
  localparam logic [31:0] FD2_VER_CYC = 32'(`CYC_MIN(`WAIT_FD2_VER_CSI_NS));
  localparam logic [31:0] COM_CSI_CYC = 32'(`CYC_MIN(`WAIT_COM_CSI_NS));
  localparam logic [31:0] COM_UART_CYC = 32'(`CYC_MIN(`WAIT_COM_UART_NS));
  // The mode window, FD1 wait and command bounds are divided; other link waits stay exact.
  localparam logic [31:0] TICK_NS = 32'(`CLK_PERIOD_NS) * TIME_DIV;
  localparam logic [31:0] MODE_START_CYC =
    32'(`DIV_UP(`MODE_CNT_START_NS, TICK_NS));
  localparam logic [31:0] MODE_FINISH_CYC =
    32'(`DIV_DN(`MODE_CNT_FINISH_NS, TICK_NS));
  localparam logic [31:0] FD1_CSI_CYC =
    32'(`DIV_UP(`WAIT_FD1_CSI_NS, TICK_NS));
  localparam logic [47:0] CE_BASE_MIN_CYC =
    48'(`DIV_UP(`CE_BASE_MIN_NS, TICK_NS));
  localparam logic [47:0] CE_BASE_MAX_CYC =
    48'(`DIV_DN(`CE_BASE_MAX_NS, TICK_NS));
  localparam logic [47:0] BLK_MIN_CYC =
    48'(`DIV_UP(`ERASE_BLK_MIN_NS, TICK_NS));
  localparam logic [47:0] CE_BLK_MAX_CYC =
    48'(`DIV_DN(`CE_BLK_MAX_NS, TICK_NS));
  localparam logic [47:0] BE_BASE_MIN_CYC =
    48'(`DIV_UP(`BE_BASE_NS, TICK_NS));
  localparam logic [47:0] BE_BASE_MAX_CYC =
    48'(`DIV_DN(`BE_BASE_NS, TICK_NS));
  localparam logic [47:0] BE_PASS_MIN_CYC =
    48'(`DIV_UP(`BE_PASS_MIN_NS, TICK_NS));
  localparam logic [47:0] BE_PASS_MAX_CYC =
    48'(`DIV_DN(`BE_PASS_MAX_NS, TICK_NS));
  localparam logic [47:0] BE_BLK_MAX_CYC =
    48'(`DIV_DN(`BE_BLK_MAX_NS, TICK_NS));
  localparam logic [47:0] PU_MIN_CYC =
    48'(`DIV_UP(`PU_MIN_NS, TICK_NS));
  localparam logic [47:0] PU_MAX_CYC =
    48'(`DIV_DN(`PU_MAX_NS, TICK_NS));
  localparam logic [47:0] PB0_MIN_CYC =
    48'(`DIV_UP(`PB0_MIN_NS, TICK_NS));
  localparam logic [47:0] PB0_MAX_CYC =
    48'(`DIV_DN(`PB0_MAX_NS, TICK_NS));
  localparam logic [47:0] PBN_MAX_CYC =
    48'(`DIV_DN(`PBN_MAX_NS, TICK_NS));

  ////////////////////////////////////////////////////////////////////////////
  // Mode entry pulse counter.

  logic [31:0] win_cnt;
  logic [31:0] next_win_cnt;
  logic        pin_prev;
  logic [7:0]  next_mode_count;
  logic        next_mode_count_valid;
  logic        pin_rise;
  logic        in_window;

  assign pin_rise  = flash_mode_select_pin && !pin_prev;
  assign in_window = (win_cnt >= MODE_START_CYC) &&
                     (win_cnt < MODE_FINISH_CYC); // R1 R2

  always_comb begin
    next_win_cnt          = win_cnt;
    next_mode_count       = mode_count;
    next_mode_count_valid = mode_count_valid;
    if (win_cnt < MODE_FINISH_CYC) begin
      next_win_cnt = win_cnt + 32'h1;
    end else begin
      next_mode_count_valid = 1'b1; // R2
    end
    // Edges outside the window are ignored, so early bounce is harmless.
    if (pin_rise && in_window && mode_count != 8'hff) begin // R1
      next_mode_count = mode_count + 8'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      win_cnt          <= 32'h0;
      pin_prev         <= 1'b0;
      mode_count       <= 8'h0;
      mode_count_valid <= 1'b0;
    end else begin
      win_cnt          <= next_win_cnt;
      pin_prev         <= flash_mode_select_pin;
      mode_count       <= next_mode_count;
      mode_count_valid <= next_mode_count_valid;
    end
  end

  assign count_window_open = in_window;

  ////////////////////////////////////////////////////////////////////////////
  // Minimum wait after each transfer.

  logic [31:0] wait_load;

  always_comb begin
    wait_load = 32'h0;
    unique case (flash_prog_pkg::xfer_kind_t'(xfer_kind))
      flash_prog_pkg::XFER_DATA_RX: begin
        wait_load = link_uart ? DR_UART_CYC : DR_CSI_CYC;
      end
      flash_prog_pkg::XFER_DATA_TX: begin
        wait_load = link_uart ? 32'h0 : DT_CSI_CYC;
      end
      flash_prog_pkg::XFER_STATUS_RQ: begin
        wait_load = link_uart ? 32'h0 : SF_CSI_CYC;
      end
      flash_prog_pkg::XFER_FD1: begin
        // The per-block product fits 32 bits for up to 255 blocks.
        wait_load = link_uart ? 32'h0 :
                    32'(FD1_CSI_CYC * 32'(xfer_blocks)); // R14
      end
      flash_prog_pkg::XFER_FD2_SIG: begin
        wait_load = link_uart ? 32'h0 : FD2_SIG_CYC;
      end
      flash_prog_pkg::XFER_FD2_VER: begin
        wait_load = link_uart ? 32'h0 : FD2_VER_CYC;
      end
      flash_prog_pkg::XFER_FD3: begin
        wait_load = link_uart ? FD3_UART_CYC : FD3_CSI_CYC;
      end
      flash_prog_pkg::XFER_COM: begin
        wait_load = link_uart ? COM_UART_CYC : COM_CSI_CYC;
      end
    endcase
  end

  min_wait_timer u_link_wait (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .load       (xfer_end),
    .load_value (wait_load),
    .ready      (link_ready) // R13
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command completion window and erase pass walk.

  flash_prog_pkg::cmd_state_t state;
  flash_prog_pkg::cmd_state_t next_state;
  flash_prog_pkg::cmd_kind_t  kind;
  flash_prog_pkg::cmd_kind_t  next_kind;
  logic [7:0]  first_block, next_first_block;
  logic [7:0]  blk_total, next_blk_total;
  logic [7:0]  pass_block, next_pass_block;
  logic [7:0]  remaining, next_remaining;
  logic [47:0] min_bound, next_min_bound;
  logic [47:0] max_bound, next_max_bound;
  logic [47:0] elapsed, next_elapsed;
  logic        done_pend, next_done_pend;
  logic        next_cmd_done;
  logic        next_cmd_timeout;
  logic        next_pass_valid;
  logic [7:0]  next_pass_blk;
  logic [7:0]  next_pass_size;
  logic [7:0]  next_pass_count;
  logic [2:0]  plan_log2;
  logic [7:0]  plan_size;

  erase_pass_planner u_planner (
    .start_block (pass_block),
    .remaining   (remaining),
    .size_log2   (plan_log2),
    .size        (plan_size)
  );

  always_comb begin
    next_state       = state;
    next_kind        = kind;
    next_first_block = first_block;
    next_blk_total   = blk_total;
    next_pass_block  = pass_block;
    next_remaining   = remaining;
    next_min_bound   = min_bound;
    next_max_bound   = max_bound;
    next_elapsed     = elapsed;
    next_done_pend   = done_pend;
    next_cmd_done    = 1'b0;
    next_cmd_timeout = 1'b0;
    next_pass_valid  = 1'b0;
    next_pass_blk    = erase_pass_block;
    next_pass_size   = erase_pass_size;
    next_pass_count  = erase_pass_count;
    unique case (state)
      flash_prog_pkg::CMD_IDLE: begin
        if (cmd_start) begin
          next_kind        = flash_prog_pkg::cmd_kind_t'(cmd_kind);
          next_first_block = cmd_first_block;
          next_blk_total   = cmd_block_count;
          next_pass_block  = cmd_first_block;
          next_remaining   = cmd_block_count;
          next_elapsed     = 48'h0;
          next_done_pend   = 1'b0;
          next_pass_count  = 8'h0;
          next_state       = flash_prog_pkg::CMD_RUN;
          unique case (flash_prog_pkg::cmd_kind_t'(cmd_kind))
            flash_prog_pkg::CHIP_ERASE: begin
              next_min_bound = CE_BASE_MIN_CYC +
                               48'(cmd_block_count) * BLK_MIN_CYC; // R17
              next_max_bound = CE_BASE_MAX_CYC +
                               48'(cmd_block_count) * CE_BLK_MAX_CYC;
            end
            flash_prog_pkg::BLOCK_ERASE: begin
              next_min_bound = BE_BASE_MIN_CYC; // R18
              next_max_bound = BE_BASE_MAX_CYC;
              if (cmd_block_count != 8'h0) begin
                next_state = flash_prog_pkg::CMD_PLAN;
              end
            end
            flash_prog_pkg::PROG_UNIT: begin
              next_min_bound = PU_MIN_CYC; // R19
              next_max_bound = PU_MAX_CYC;
            end
            flash_prog_pkg::PROG_BLOCK: begin
              next_min_bound = (cmd_first_block == 8'h0) ?
                               PB0_MIN_CYC : 48'h1; // R20
              next_max_bound = (cmd_first_block == 8'h0) ?
                               PB0_MAX_CYC : PBN_MAX_CYC;
            end
          endcase
        end
      end
      flash_prog_pkg::CMD_PLAN: begin
        // One pass is issued, then the array must finish it before the next.
        next_elapsed    = elapsed + 48'h1;
        next_pass_valid = 1'b1; // R21
        next_pass_blk   = pass_block;
        next_pass_size  = plan_size;
        next_pass_count = erase_pass_count + 8'h1;
        next_min_bound  = min_bound + BE_PASS_MIN_CYC +
                          (BLK_MIN_CYC << plan_log2); // R18
        next_max_bound  = max_bound + BE_PASS_MAX_CYC +
                          (BE_BLK_MAX_CYC << plan_log2);
        next_pass_block = pass_block + plan_size;
        next_remaining  = remaining - plan_size;
        next_state      = flash_prog_pkg::CMD_RUN;
      end
      flash_prog_pkg::CMD_RUN: begin
        next_elapsed = elapsed + 48'h1;
        if (array_done && kind == flash_prog_pkg::BLOCK_ERASE &&
            remaining != 8'h0) begin
          next_state = flash_prog_pkg::CMD_PLAN; // R21
        end else if ((array_done || done_pend) &&
                     elapsed >= min_bound) begin // R16
          next_cmd_done = 1'b1;
          next_state    = flash_prog_pkg::CMD_END;
        end else if (elapsed >= max_bound) begin // R16
          next_cmd_timeout = 1'b1;
          next_state       = flash_prog_pkg::CMD_END;
        end else if (array_done) begin
          // An early finish is held back until the minimum has passed.
          next_done_pend = 1'b1;
        end
      end
      flash_prog_pkg::CMD_END: begin
        next_state = flash_prog_pkg::CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state            <= flash_prog_pkg::CMD_IDLE;
      kind             <= flash_prog_pkg::CHIP_ERASE;
      first_block      <= 8'h0;
      blk_total        <= 8'h0;
      pass_block       <= 8'h0;
      remaining        <= 8'h0;
      min_bound        <= 48'h0;
      max_bound        <= 48'h0;
      elapsed          <= 48'h0;
      done_pend        <= 1'b0;
      cmd_done         <= 1'b0;
      cmd_timeout      <= 1'b0;
      erase_pass_valid <= 1'b0;
      erase_pass_block <= 8'h0;
      erase_pass_size  <= 8'h0;
      erase_pass_count <= 8'h0;
    end else begin
      state            <= next_state;
      kind             <= next_kind;
      first_block      <= next_first_block;
      blk_total        <= next_blk_total;
      pass_block       <= next_pass_block;
      remaining        <= next_remaining;
      min_bound        <= next_min_bound;
      max_bound        <= next_max_bound;
      elapsed          <= next_elapsed;
      done_pend        <= next_done_pend;
      cmd_done         <= next_cmd_done;
      cmd_timeout      <= next_cmd_timeout;
      erase_pass_valid <= next_pass_valid;
      erase_pass_block <= next_pass_blk;
      erase_pass_size  <= next_pass_size;
      erase_pass_count <= next_pass_count;
    end
  end

  assign cmd_busy = (state != flash_prog_pkg::CMD_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence plan_step_s;
    state == flash_prog_pkg::CMD_PLAN;
  endsequence

  sequence pass_out_s;
    state == flash_prog_pkg::CMD_RUN ##0 erase_pass_valid;
  endsequence

  count_start_a: assert property ( // R1
    pin_rise && !in_window |=> mode_count == $past(mode_count))
    else $error("Mode pulse counted outside the window.");

  count_freeze_a: assert property ( // R2
    mode_count_valid |=> mode_count_valid && $stable(mode_count))
    else $error("Mode count changed after the window closed.");

  window_end_a: assert property ( // R2
    $rose(mode_count_valid) |-> win_cnt == MODE_FINISH_CYC)
    else $error("Mode count valid at the wrong time.");

  link_gate_a: assert property ( // R13
    xfer_end && wait_load > 32'h1 |=> !link_ready ##1 !link_ready)
    else $error("Link ready before the minimum wait.");

  fd1_hold_a: assert property ( // R14
    xfer_end && !link_uart && xfer_blocks != 8'h0 &&
    xfer_kind == flash_prog_pkg::XFER_FD1 |=> !link_ready [*8])
    else $error("Data frames allowed too soon after status.");

  done_min_a: assert property ( // R16
    cmd_done |-> elapsed > min_bound && $past(state) == flash_prog_pkg::CMD_RUN)
    else $error("Command completed before its minimum.");

  timeout_max_a: assert property ( // R16
    cmd_timeout |-> elapsed > max_bound && !cmd_done)
    else $error("Timeout raised before the maximum.");

  chip_erase_a: assert property ( // R17
    cmd_done && kind == flash_prog_pkg::CHIP_ERASE |->
    elapsed > CE_BASE_MIN_CYC + 48'(blk_total) * BLK_MIN_CYC)
    else $error("Chip erase completed too early.");

  pass_seq_a: assert property ( // R18
    plan_step_s |=> pass_out_s)
    else $error("Erase pass not issued after planning.");

  prog_unit_a: assert property ( // R19
    cmd_done && kind == flash_prog_pkg::PROG_UNIT |-> elapsed > PU_MIN_CYC)
    else $error("Program unit completed too early.");

  block0_a: assert property ( // R20
    cmd_done && kind == flash_prog_pkg::PROG_BLOCK && first_block == 8'h0
    |-> elapsed > PB0_MIN_CYC)
    else $error("Block 0 program completed too early.");

  pass_align_a: assert property ( // R21
    erase_pass_valid |-> erase_pass_size != 8'h0 &&
    erase_pass_size <= 8'(`MAX_GROUP) &&
    (erase_pass_block & (erase_pass_size - 8'h1)) == 8'h0)
    else $error("Erase pass group misaligned or oversized.");
endmodule
`default_nettype wire

// ==== flash_array_model.sv ====
// Flash array stand-in that answers each operation or erase pass late.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Start of an operation or pass, and the answer delay.
  input  wire logic        start,
  input  wire logic [15:0] delay,
  // Completion.
  output logic             array_done
);
  logic        armed;
  logic [15:0] left;
  // A new start reloads the delay, so a long delay only answers if left alone.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed      <= 1'b0;
      left       <= 16'h0000;
      array_done <= 1'b0;
    end else begin
      array_done <= 1'b0;
      if (start) begin
        armed <= 1'b1;
        left  <= delay;
      end else if (armed && left == 16'h0000) begin
        armed      <= 1'b0;
        array_done <= 1'b1;
      end else if (armed) begin
        left <= left - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the programming-mode timing sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        flash_mode_select_pin = 1'b0;
  logic        link_uart = 1'b0;
  logic        xfer_end = 1'b0;
  logic [2:0]  xfer_kind = 3'h0;
  logic [7:0]  xfer_blocks = 8'h00;
  logic        cmd_start = 1'b0;
  logic [1:0]  cmd_kind = 2'h0;
  logic [7:0]  cmd_first_block = 8'h00;
  logic [7:0]  cmd_block_count = 8'h00;
  logic [15:0] delay = 16'h0000;
  logic        array_done, count_window_open, mode_count_valid, link_ready;
  logic        cmd_busy, cmd_done, cmd_timeout, erase_pass_valid, arm;
  logic [7:0]  mode_count, erase_pass_block, erase_pass_size, erase_pass_count;
  logic [15:0] passes [$];
  int          n_fail = 0;
  int          samples_checked = 0;
  always #4 clk = ~clk;
  // Block erase is answered per pass, the other commands once per start.
  assign arm = erase_pass_valid | (cmd_start & (cmd_kind != 2'h1));
  always @(posedge clk) begin
    if (erase_pass_valid === 1'b1) begin
      passes.push_back({erase_pass_block, erase_pass_size});
    end
  end
  flash_prog_mode_timing #(.TIME_DIV(32'hc350)) dut_u (
    .clk, .sys_rst, .flash_mode_select_pin, .count_window_open, .mode_count,
    .mode_count_valid, .link_uart, .xfer_end, .xfer_kind, .xfer_blocks,
    .link_ready, .cmd_start, .cmd_kind, .cmd_first_block, .cmd_block_count,
    .array_done, .cmd_busy, .cmd_done, .cmd_timeout, .erase_pass_valid,
    .erase_pass_block, .erase_pass_size, .erase_pass_count
  );
  flash_array_model partner_u (.clk, .sys_rst, .start(arm), .delay, .array_done);
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_range(input int d, input int lo, input int hi);
    samples_checked++;
    if (d < lo || d > hi) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, d, lo);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse;
    flash_mode_select_pin = 1'b1;
    cyc(1);
    flash_mode_select_pin = 1'b0;
    cyc(1);
  endtask
  // Duration counts falling edges from the start until done or timeout.
  task automatic run_cmd(input logic [1:0] k, input logic [7:0] f,
      input logic [7:0] n, input logic [15:0] dl, input logic ok,
      input int lo, input int hi);
    int d = 0;
    cmd_kind = k;
    cmd_first_block = f;
    cmd_block_count = n;
    delay = dl;
    cmd_start = 1'b1;
    cyc(1);
    cmd_start = 1'b0;
    check_val(cmd_busy, 1'b1);
    while (cmd_done !== 1'b1 && cmd_timeout !== 1'b1 && d < 4000) begin
      d++;
      cyc(1);
    end
    if (d == 4000) begin
      n_fail++;
      print_verdict();
    end
    check_val(cmd_done, ok);
    check_range(d, lo, hi);
    cyc(2);
    check_val(cmd_busy, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_mode;
    cyc(2);
    pulse();
    pulse();
    check_val(count_window_open, 1'b0);
    cyc(44);
    check_val(count_window_open, 1'b1);
    repeat (3) pulse();
    cyc(36);
    check_val(count_window_open, 1'b0);
    pulse();
    check_val(mode_count, 32'h3);
    check_val(mode_count_valid, 1'b1);
  endtask
  task automatic test_link;
    logic [2:0] k [14] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 5, 6, 6, 7, 7};
    logic       u [14] = '{0, 1, 0, 1, 0, 1, 0, 1, 0, 0, 0, 1, 0, 1};
    int         e [14] = '{3704, 3282, 2892, 0, 9454, 0, 102, 0, 10829, 7625,
                           385, 3704, 4500, 4360};
    int         n;
    for (int i = 0; i < 14; i++) begin
      xfer_kind = k[i];
      link_uart = u[i];
      xfer_blocks = 8'h03;
      xfer_end = 1'b1;
      cyc(1);
      xfer_end = 1'b0;
      n = 0;
      while (link_ready === 1'b0 && n < 12000) begin
        n++;
        cyc(1);
      end
      check_val(n, e[i]);
    end
  endtask
  task automatic test_chip_erase;
    run_cmd(2'h0, 8'h00, 8'h02, 16'h0005, 1'b1, 292, 294);
    run_cmd(2'h0, 8'h00, 8'h02, 16'hffff, 1'b0, 3188, 3190);
  endtask
  task automatic test_block_erase;
    logic [15:0] exp [4] = '{16'h0501, 16'h0602, 16'h0802, 16'h0a01};
    passes.delete();
    run_cmd(2'h1, 8'h05, 8'h06, 16'h0003, 1'b1, 317, 319);
    check_val(passes.size(), 32'h4);
    check_val(erase_pass_count, 32'h4);
    for (int i = 0; i < 4; i++) begin
      check_val(passes[i], exp[i]);
    end
  endtask
  task automatic test_program;
    run_cmd(2'h2, 8'h00, 8'h00, 16'h0064, 1'b1, 100, 106);
    run_cmd(2'h3, 8'h00, 8'h00, 16'hffff, 1'b0, 1940, 1942);
    run_cmd(2'h3, 8'h00, 8'h00, 16'h0064, 1'b1, 259, 261);
    run_cmd(2'h3, 8'h05, 8'h00, 16'h0000, 1'b1, 1, 6);
  endtask
  initial begin
    cyc(3);
    sys_rst = 1'b0;
    test_mode();
    test_link();
    test_chip_erase();
    test_block_erase();
    test_program();
    print_verdict();
  end
endmodule
`default_nettype wire
